//--- bldc_commutation_sequencer.v
// Functional notes
// - each run state drives one low side and one high side, different phases
// - each rising rate-clock edge in ramp and run steps A..F and wraps back to A
// - align state: low B, high A and C on, no sensing
// - state A: low C, high A, sense phase B
// - state B: low C, high B, sense phase A
// - state C: low A, high B, sense phase C
// - state D: low A, high C, sense phase B
// - state E: low B, high C, sense phase A
// - state F: low B, high A, sense phase C
// - low drives active high, high drives active low
// - overcurrent fires one-shot forcing all low drives off
// - low drive outputs combine state decode, PWM duty, current-limit shutdown and undervoltage; high drives use state decode and undervoltage only
// - undervoltage turns every driver off until it clears
// - rate clock is echoed on a tachometer output
// - start-up goes align, then ramp, then back-EMF run
// - reset enters align, holds R until align timer trips, then ramp
// - ramp steps A..F without sensing, run when ramp timer trips
// - run mode enables back-EMF sampling
`timescale 1ns/1ps
`default_nettype none
`include "commutation_defs.vh"

module bldc_commutation_sequencer
(
	input  wire       i_clk_sys,
	input  wire       i_srst,
	input  wire       i_rate_clock,      // oscillator clock, async
	input  wire       i_pwm_duty,        // speed loop duty, async
	input  wire       i_overcurrent,     // current comparator, async
	input  wire       i_undervolt_flag_n,// low when supply is low, async
	input  wire       i_align_done,      // align timing comparator, async
	input  wire       i_ramp_done,       // ramp timing comparator, async
	output reg        o_low_drive_a,
	output reg        o_low_drive_b,
	output reg        o_low_drive_c,
	output reg        o_high_drive_a_n,
	output reg        o_high_drive_b_n,
	output reg        o_high_drive_c_n,
	output reg  [1:0] o_sense_select,
	output reg        o_sample_enable,
	output reg  [1:0] o_mode,
	output reg        o_rate_clock_out
);

	// ----------------------------------------------------------------
	// input synchronisers
	// ----------------------------------------------------------------
	reg [5:0] sync1_reg;
	reg [5:0] sync2_reg;
	reg       rate_prev_reg;

	// two flops on every outside input
	always @(posedge i_clk_sys)
	begin
		if (i_srst)
		begin
			sync1_reg <= 6'h10; // undervolt flag idles high
			sync2_reg <= 6'h10;
		end
		else
		begin
			sync1_reg <= {i_ramp_done, i_undervolt_flag_n, i_align_done,
				i_overcurrent, i_pwm_duty, i_rate_clock};
			sync2_reg <= sync1_reg;
		end
	end

	wire rate_s    = sync2_reg[0];
	wire pwm_s     = sync2_reg[1];
	wire ocur_s    = sync2_reg[2];
	wire align_s   = sync2_reg[3];
	wire uv_n_s    = sync2_reg[4];
	wire ramp_s    = sync2_reg[5];

	// rising edge of the rate clock steps the sequencer
	always @(posedge i_clk_sys)
	begin
		if (i_srst)
			rate_prev_reg <= 1'b0;
		else
			rate_prev_reg <= rate_s;
	end

	wire rate_step = rate_s & ~rate_prev_reg;

	// ----------------------------------------------------------------
	// current-limit one-shot
	// ----------------------------------------------------------------
	wire offtime_active;

	offtime_oneshot u_offtime
	(
		.i_clk_sys (i_clk_sys),
		.i_srst    (i_srst),
		.i_trip    (ocur_s),
		.o_active  (offtime_active)
	);

	// ----------------------------------------------------------------
	// start-up mode and commutation state
	// ----------------------------------------------------------------
	reg [1:0] mode_reg;
	reg [1:0] mode_next;
	reg [2:0] state_reg;
	reg [2:0] state_next;

	// next state in the six-step ring
	function [2:0] step_state;
		input [2:0] s;
		begin
			case (s)
				`ST_A:   step_state = `ST_B;
				`ST_B:   step_state = `ST_C;
				`ST_C:   step_state = `ST_D;
				`ST_D:   step_state = `ST_E;
				`ST_E:   step_state = `ST_F;
				`ST_F:   step_state = `ST_A;
				default: step_state = `ST_A;
			endcase
		end
	endfunction

	// mode sequencing and stepping
	always @*
	begin
		mode_next  = mode_reg;
		state_next = state_reg;
		case (mode_reg)
			`MODE_ALIGN:
			begin
				state_next = `ST_ALIGN;
				if (align_s)
				begin
					mode_next  = `MODE_RAMP;
					state_next = `ST_A;
				end
			end
			`MODE_RAMP:
			begin
				if (rate_step)
					state_next = step_state(state_reg);
				if (ramp_s)
					mode_next = `MODE_RUN;
			end
			`MODE_RUN:
			begin
				if (rate_step)
					state_next = step_state(state_reg);
			end
			default:
			begin
				mode_next  = `MODE_ALIGN;
				state_next = `ST_ALIGN;
			end
		endcase
	end

	always @(posedge i_clk_sys)
	begin
		if (i_srst)
		begin
			mode_reg  <= `MODE_ALIGN;
			state_reg <= `ST_ALIGN;
		end
		else
		begin
			mode_reg  <= mode_next;
			state_reg <= state_next;
		end
	end

	// ----------------------------------------------------------------
	// state decode: {low a,b,c, high a,b,c} active high, sense select
	// ----------------------------------------------------------------
	reg [5:0] drive_dec;
	reg [1:0] sense_dec;

	always @*
	begin
		case (state_reg)
			`ST_ALIGN:
			begin
				drive_dec = 6'h15;
				sense_dec = `SENSE_NONE;
			end
			`ST_A:
			begin
				drive_dec = 6'h0c;
				sense_dec = `SENSE_B;
			end
			`ST_B:
			begin
				drive_dec = 6'h0a;
				sense_dec = `SENSE_A;
			end
			`ST_C:
			begin
				drive_dec = 6'h22;
				sense_dec = `SENSE_C;
			end
			`ST_D:
			begin
				drive_dec = 6'h21;
				sense_dec = `SENSE_B;
			end
			`ST_E:
			begin
				drive_dec = 6'h11;
				sense_dec = `SENSE_A;
			end
			`ST_F:
			begin
				drive_dec = 6'h14;
				sense_dec = `SENSE_C;
			end
			default:
			begin
				drive_dec = 6'h00; // unused code: all off
				sense_dec = `SENSE_NONE;
			end
		endcase
	end
	// every run-state pattern above has one low and one high bit

	// ----------------------------------------------------------------
	// output combine and registers
	// ----------------------------------------------------------------
	wire low_gate  = pwm_s & ~offtime_active & uv_n_s;
	wire high_gate = uv_n_s;

	// gate drive registers, all switches off in reset
	always @(posedge i_clk_sys)
	begin
		if (i_srst)
		begin
			o_low_drive_a    <= 1'b0;
			o_low_drive_b    <= 1'b0;
			o_low_drive_c    <= 1'b0;
			o_high_drive_a_n <= 1'b1;
			o_high_drive_b_n <= 1'b1;
			o_high_drive_c_n <= 1'b1;
		end
		else
		begin
			o_low_drive_a    <= drive_dec[5] & low_gate;
			o_low_drive_b    <= drive_dec[4] & low_gate;
			o_low_drive_c    <= drive_dec[3] & low_gate;
			o_high_drive_a_n <= ~(drive_dec[2] & high_gate);
			o_high_drive_b_n <= ~(drive_dec[1] & high_gate);
			o_high_drive_c_n <= ~(drive_dec[0] & high_gate);
		end
	end

	// sense select, mode and tachometer registers
	always @(posedge i_clk_sys)
	begin
		if (i_srst)
		begin
			o_sense_select   <= `SENSE_NONE;
			o_sample_enable  <= 1'b0;
			o_mode           <= `MODE_ALIGN;
			o_rate_clock_out <= 1'b0;
		end
		else
		begin
			o_sense_select   <= sense_dec;
			o_sample_enable  <= (mode_reg == `MODE_RUN);
			o_mode           <= mode_reg;
			o_rate_clock_out <= rate_s;
		end
	end

endmodule // bldc_commutation_sequencer

`default_nettype wire

//--- commutation_defs.vh
`ifndef COMMUTATION_DEFS_VH
`define COMMUTATION_DEFS_VH

// ----------------------------------------------------------------
// sequencer state codes
// ----------------------------------------------------------------
`define ST_ALIGN        3'h0
`define ST_A            3'h1
`define ST_B            3'h2
`define ST_C            3'h3
`define ST_D            3'h4
`define ST_E            3'h5
`define ST_F            3'h6

// ----------------------------------------------------------------
// start-up modes
// ----------------------------------------------------------------
`define MODE_ALIGN      2'h0
`define MODE_RAMP       2'h1
`define MODE_RUN        2'h2

// ----------------------------------------------------------------
// sense select codes
// ----------------------------------------------------------------
`define SENSE_NONE      2'h0
`define SENSE_A         2'h1
`define SENSE_B         2'h2
`define SENSE_C         2'h3

// ----------------------------------------------------------------
// current-limit off time
// ----------------------------------------------------------------
`define OFFTIME_NS      20000
`define CLK_PERIOD_NS   10
`define OFFTIME_CYCLES  ((`OFFTIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define OFF_CNT_W       16

`endif

//--- offtime_oneshot.v
`timescale 1ns/1ps
`default_nettype none
`include "commutation_defs.vh"

module offtime_oneshot
#(
	parameter OFF_CYCLES = `OFFTIME_CYCLES
)
(
	input  wire i_clk_sys,
	input  wire i_srst,
	input  wire i_trip,
	output wire o_active
);

	reg [`OFF_CNT_W-1:0] count_reg;
	reg [`OFF_CNT_W-1:0] count_next;

	// ----------------------------------------------------------------
	// one-shot counter
	// ----------------------------------------------------------------
	// start only when idle; trips while running are ignored
	always @*
	begin
		count_next = count_reg;
		if (count_reg != {`OFF_CNT_W{1'b0}})
			count_next = count_reg - {{(`OFF_CNT_W-1){1'b0}}, 1'b1};
		else if (i_trip)
			count_next = OFF_CYCLES[`OFF_CNT_W-1:0];
	end

	always @(posedge i_clk_sys)
	begin
		if (i_srst)
			count_reg <= {`OFF_CNT_W{1'b0}};
		else
			count_reg <= count_next;
	end

	assign o_active = (count_reg != {`OFF_CNT_W{1'b0}});

endmodule // offtime_oneshot

`default_nettype wire

//--- pstage_model.sv
`timescale 1ns/1ps
`default_nettype none
module pstage_model (
	input wire logic       i_clk_sys,
	input wire logic [2:0] i_low,
	input wire logic [2:0] i_high_n,
	output var logic       o_shoot
);
	initial o_shoot = 1'b0;
	// a high switch conducts when its gate pin is low; latch any leg short
	always @(posedge i_clk_sys)
		if ((i_low & ~i_high_n) != 3'h0) o_shoot <= 1'b1;
endmodule // pstage_model
`default_nettype wire

//--- seq_checker.sv
`timescale 1ns/1ps
`default_nettype none
module seq_checker (
	input wire logic       i_clk_sys, i_srst, i_rate_clock, i_pwm_duty,
	input wire logic       i_overcurrent, i_undervolt_flag_n,
	input wire logic       o_low_drive_a, o_low_drive_b, o_low_drive_c,
	input wire logic       o_high_drive_a_n, o_high_drive_b_n, o_high_drive_c_n,
	input wire logic [1:0] o_sense_select, o_mode,
	input wire logic       o_sample_enable, o_rate_clock_out
);
	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (i_srst);
	// gate states as on-vectors, phase a first
	wire [2:0] lo = {o_low_drive_a, o_low_drive_b, o_low_drive_c};
	wire [2:0] hi = ~{o_high_drive_a_n, o_high_drive_b_n, o_high_drive_c_n};
	a_one_low: assert property ($onehot0(lo) && !(lo & hi))
		else $error("low drive overlap");
	a_run_sample: assert property (o_sample_enable == (o_mode == 2'h2))
		else $error("sampling mode wrong");
	a_mode_order: assert property ($past(o_mode) == 2'h0 |-> o_mode != 2'h2)
		else $error("align skipped ramp");
	a_align_quiet: assert property (o_mode == 2'h0 |-> o_sense_select == 2'h0 && !(lo & 3'h5))
		else $error("align decode wrong");
	a_uv_off: assert property (!i_undervolt_flag_n [*5] |-> lo == 3'h0 && hi == 3'h0)
		else $error("drives on in undervoltage");
	a_pwm_gate: assert property (!i_pwm_duty [*5] |-> lo == 3'h0)
		else $error("low drive on with duty low");
	a_oc_trip: assert property ($rose(i_overcurrent) |-> ##5 (lo == 3'h0) [*8])
		else $error("overcurrent left low drive on");
	a_tach_echo: assert property (!$past(i_srst, 3) |-> o_rate_clock_out == $past(i_rate_clock, 3))
		else $error("tach not following rate clock");
	c_run: cover property (o_mode == 2'h2);
	c_trip: cover property ($rose(i_overcurrent));
	c_uv: cover property (!i_undervolt_flag_n [*5]);
endmodule // seq_checker
bind bldc_commutation_sequencer seq_checker chk (
	.i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_rate_clock(i_rate_clock),
	.i_pwm_duty(i_pwm_duty), .i_overcurrent(i_overcurrent),
	.i_undervolt_flag_n(i_undervolt_flag_n), .o_low_drive_a(o_low_drive_a),
	.o_low_drive_b(o_low_drive_b), .o_low_drive_c(o_low_drive_c),
	.o_high_drive_a_n(o_high_drive_a_n), .o_high_drive_b_n(o_high_drive_b_n),
	.o_high_drive_c_n(o_high_drive_c_n), .o_sense_select(o_sense_select),
	.o_mode(o_mode), .o_sample_enable(o_sample_enable), .o_rate_clock_out(o_rate_clock_out)
);
`default_nettype wire

//--- test_bldc_commutation_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin fails++; \
	$display("MISMATCH %s exp %h got %h", n, e, s); end end
module test_bldc_commutation_sequencer;
	logic clk = 0, srst = 1, rate = 0, pwm = 1, oc = 0, uvn = 1, ad = 0, rd = 0;
	wire [2:0] lo, hn;
	wire [1:0] sen, mode;
	wire       se, tach, shoot;
	wire [7:0] v = {lo, hn, sen};
	int        checked = 0, fails = 0, cyc = 0;
	logic [7:0] tbl [6] = '{8'h35, 8'h97, 8'h9a, 8'h59, 8'h4f, 8'h2e};
	always #5 clk = ~clk;
	bldc_commutation_sequencer uut (
		.i_clk_sys(clk), .i_srst(srst), .i_rate_clock(rate), .i_pwm_duty(pwm),
		.i_overcurrent(oc), .i_undervolt_flag_n(uvn), .i_align_done(ad),
		.i_ramp_done(rd), .o_low_drive_a(lo[2]), .o_low_drive_b(lo[1]),
		.o_low_drive_c(lo[0]), .o_high_drive_a_n(hn[2]), .o_high_drive_b_n(hn[1]),
		.o_high_drive_c_n(hn[0]), .o_sense_select(sen), .o_sample_enable(se),
		.o_mode(mode), .o_rate_clock_out(tach)
	);
	pstage_model far (.i_clk_sys(clk), .i_low(lo), .i_high_n(hn), .o_shoot(shoot));
	task cy(input int n);
		repeat (n) @(posedge clk);
	endtask
	// one rate clock pulse, then the decoded state
	task step(input logic [7:0] e);
		rate <= 1'b1;
		cy(5);
		`CHK("tach", 1'b1, tach)
		rate <= 1'b0;
		cy(5);
		`CHK("state", e, v)
	endtask
	task t_start;
		cy(8);
		`CHK("align", 8'h48, v)
		step(8'h48);
		`CHK("align mode", 2'h0, mode)
		ad <= 1'b1;
		cy(8);
		`CHK("ramp a", 11'h22e, {mode, se, v})
		for (int i = 0; i < 6; i++) step(tbl[i]);
		$display("start test done");
	endtask
	task t_gate;
		pwm <= 1'b0;
		cy(6);
		`CHK("pwm off", 8'h0e, v)
		pwm <= 1'b1;
		uvn <= 1'b0;
		cy(6);
		`CHK("uv", 6'h07, v[7:2])
		uvn <= 1'b1;
		cy(6);
		`CHK("uv clear", 8'h2e, v)
		$display("gate test done");
	endtask
	// second trip mid-interval must not stretch it
	task t_oc;
		oc <= 1'b1;
		cy(3);
		oc <= 1'b0;
		cy(20);
		`CHK("oc off", 8'h0e, v)
		cy(977);
		oc <= 1'b1;
		cy(3);
		oc <= 1'b0;
		cy(997);
		`CHK("oc hold", 8'h0e, v)
		cy(100);
		`CHK("oc end", 8'h2e, v)
		$display("overcurrent test done");
	endtask
	task t_run;
		rd <= 1'b1;
		cy(8);
		`CHK("run", 11'h52e, {mode, se, v})
		step(8'h35);
		`CHK("shoot", 1'b0, shoot)
		$display("run test done");
	endtask
	task results;
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 6000)
		begin
			fails++;
			results;
		end
	end
	initial
	begin
		cy(10);
		srst <= 1'b0;
		t_start;
		t_gate;
		t_oc;
		t_run;
		results;
	end
endmodule // test_bldc_commutation_sequencer
`default_nettype wire
